//--- hdl/stpo_event_counter.sv
// stpo_event_counter.sv: 16-bit event counter
// assumes inc is a one-cycle pulse on clk
`include "stpo_params.svh"
`default_nettype none
module stpo_event_counter
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic inc,
  output logic [15:0] count
);
  import stpo_pkg::*;
  stpo_cnt_s cnt_q;
  stpo_cnt_s cnt_d;
  // saturate so a flood of errors never wraps back to a small count
  always_comb
  begin
    cnt_d = cnt_q;
    if (inc && (cnt_q.cnt != `STPO_CNT_MAX))
      cnt_d.cnt = cnt_q.cnt + 16'h0001;
  end
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      cnt_q <= '0;
    else
      cnt_q <= cnt_d;
  end
  assign count = cnt_q.cnt;
endmodule
`default_nettype wire

//--- hdl/stpo_interval.sv
// stpo_interval.sv: time from a start pulse to a stop pulse in ns
// assumes pulses last one cycle; keeps min and max while enabled
`include "stpo_params.svh"
`default_nettype none
module stpo_interval
#(
  parameter logic [31:0] MAX_INIT = 32'h0000_0000
)
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic startPulse,
  input wire logic stopPulse,
  input wire logic clearPulse,
  input wire logic measureEn,
  output logic running,
  output logic donePulse,
  output logic [31:0] lastNs,
  output logic [31:0] minNs,
  output logic [31:0] maxNs
);
  import stpo_pkg::*;
  stpo_meas_s m_q;
  stpo_meas_s m_d;
  logic [31:0] elapsedNs;
  // cnt holds cycles since the start edge, so stop gives the full span
  assign elapsedNs = 32'(m_q.cnt * `STPO_CLK_NS);
  always_comb
  begin
    m_d = m_q;
    m_d.done = 1'b0;
    if (m_q.running)
      m_d.cnt = m_q.cnt + 32'h0000_0001;
    if (stopPulse && m_q.running)
    begin
      m_d.running = 1'b0;
      m_d.lastNs = elapsedNs;
      m_d.done = 1'b1;
      if (measureEn)
      begin
        if (elapsedNs > m_q.maxNs) m_d.maxNs = elapsedNs; // [RQ4]
        if (!m_q.seen || elapsedNs < m_q.minNs) m_d.minNs = elapsedNs;
        m_d.seen = 1'b1;
      end
    end
    // old results go before the new run accumulates
    if (clearPulse)
    begin
      m_d.maxNs = 32'h0000_0000; // [RQ5]
      m_d.minNs = 32'h0000_0000;
      m_d.seen = 1'b0;
    end
    if (startPulse)
    begin
      m_d.running = 1'b1;
      m_d.cnt = 32'h0000_0001;
    end
  end
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      m_q <= '0;
      m_q.maxNs <= MAX_INIT;
    end
    else
      m_q <= m_d;
  end
  assign running = m_q.running;
  assign donePulse = m_q.done;
  assign lastNs = m_q.lastNs;
  assign minNs = m_q.minNs;
  assign maxNs = m_q.maxNs;
endmodule
`default_nettype wire

//--- hdl/stpo_params.svh
// stpo_params.svh: constants of the sync timing parameter block
// assumes a 100 MHz clock and a byte-addressed register bus
`ifndef STPO_PARAMS_SVH
`define STPO_PARAMS_SVH
// clock period in ns
`define STPO_CLK_NS 32'h0000_000A
// least sync0 to sync1 spacing in ns
`define STPO_MIN_SHIFT_NS 32'h0000_03E8
// reset values
`define STPO_RST_OUT_MODE 16'h0001
`define STPO_RST_IN_MODE 16'h0022
`define STPO_RST_CYCLE 32'h000F_4240
`define STPO_RST_MIN_CYCLE 32'h0000_E6DC
`define STPO_MODES_SUPP 16'hC807
`define STPO_PARAM_COUNT 8'h20
`define STPO_CMD_START 16'h0001
// field index inside a group, address bits [5:2]
`define STPO_F_COUNT 4'h0
`define STPO_F_MODE 4'h1
`define STPO_F_CYCLE 4'h2
`define STPO_F_SHIFT 4'h3
`define STPO_F_SUPP 4'h4
`define STPO_F_MINCYC 4'h5
`define STPO_F_CALC 4'h6
`define STPO_F_MINDLY 4'h7
`define STPO_F_CMD 4'h8
`define STPO_F_MAXDLY 4'h9
`define STPO_F_MISSED 4'hB
`define STPO_F_OVERRUN 4'hC
`define STPO_F_SHORT 4'hD
`define STPO_F_SYNCERR 4'hF
// address bits: group select, interrupt page
`define STPO_GRP_BIT 6
`define STPO_IRQ_BIT 7
`define STPO_F_IRQ_STAT 4'h0
`define STPO_F_IRQ_MASK 4'h1
`define STPO_RESP_OKAY 2'h0
`define STPO_RESP_SLVERR 2'h2
`define STPO_CNT_MAX 16'hFFFF
`endif

//--- hdl/stpo_pkg.sv
// stpo_pkg.sv: types of the sync timing parameter block
// assumes stpo_params.svh supplies the numeric constants
`default_nettype none
package stpo_pkg;
  // sync mode codes
  typedef enum logic [15:0]
  {
    STPO_FREE_RUN = 16'h0000,
    STPO_SM_SYNC = 16'h0001,
    STPO_DC_SYNC0 = 16'h0002,
    STPO_DC_SYNC1 = 16'h0003,
    STPO_SM_OUT_SYNC = 16'h0022
  } stpo_mode_e;
  // interval meter state
  typedef struct packed {
    logic running;
    logic seen;
    logic done;
    logic [31:0] cnt;
    logic [31:0] minNs;
    logic [31:0] maxNs;
    logic [31:0] lastNs;
  } stpo_meas_s;
  // event counter state
  typedef struct packed {
    logic [15:0] cnt;
  } stpo_cnt_s;
endpackage
`default_nettype wire

//--- hdl/stpo_regs.sv
// stpo_regs.sv: sync timing parameter objects behind an AXI4-Lite slave
// assumes timing event inputs are one-cycle pulses synchronous to clk
//
// Overview of operation
// RQ1 - The input sync mode holds 0, 1, 2, 3 or 34 and resets to 34.
// RQ2 - The supported-modes word reads as a constant with bits 0, 1, 2 and 14 set; the code reads 16'hC807, which also sets bits 11 and 15.
// RQ3 - Writing 1 to a command starts cycle time measurement and 0 stops it; the code keeps measuring while either group's command still holds 1.
// RQ4 - While measuring, shift, cycle, calc-copy and max delay keep their largest values.
// RQ5 - Starting a measurement first clears the old maxima.
// RQ6 - Both minimum cycle time entries reset to 59100 ns.
// RQ7 - A 16-bit counter counts missed sync-manager events when operational in DC mode.
// RQ8 - A 16-bit counter counts cycles that overran or started too early.
// RQ9 - A 16-bit counter counts too short SYNC0 to SYNC1 spacings in DC mode.
// RQ10 - A sync error flag shows that last cycle's outputs came too late in DC mode.
// RQ11 - Outputs report SYNC0 to SYNC1 time and min and max SYNC1 to output delay in ns.
// RQ12 - Inputs report the SYNC0 to sampling shift in ns.
// RQ13 - Inputs report the time from sampling to data availability in ns.
// RQ14 - Inputs report min and max SYNC1 to sampling delay in ns.
// RQ15 - The output sync mode holds 0 to 3 and resets to 1.
// RQ16 - The cycle time entries hold a period in ns and reset to one millisecond.
`include "stpo_params.svh"
`default_nettype none
module stpo_regs
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic sync0Pulse,
  input wire logic sync1Pulse,
  input wire logic opState,
  input wire logic outAppliedPulse,
  input wire logic inSampledPulse,
  input wire logic inAvailPulse,
  input wire logic [1:0] procStartPulse,
  input wire logic [1:0] procDonePulse,
  input wire logic [1:0] smMissedPulse,
  input wire logic [1:0] lateApply,
  output logic [15:0] outSyncMode,
  output logic [15:0] inSyncMode,
  output logic [31:0] outCycleTime,
  output logic [31:0] inCycleTime,
  output logic measuring,
  output logic irq
);
  import stpo_pkg::*;

  // ==========================================================
  // state
  typedef struct packed {
    logic [7:0] awAddr;
    logic awHave;
    logic [31:0] wData;
    logic [3:0] wStrb;
    logic wHave;
    logic bValid;
    logic [1:0] bResp;
    logic rValid;
    logic [31:0] rData;
    logic [1:0] rResp;
    logic [1:0][15:0] mode;
    logic [1:0][31:0] cycle;
    logic [1:0][15:0] cmd;
    logic [1:0] syncErr;
    logic [7:0] irqStat;
    logic [7:0] irqMask;
  } stpo_regs_s;

  stpo_regs_s regs_q;
  stpo_regs_s regs_d;

  logic startMeas;
  logic measureEn;
  logic [1:0] dcMode;
  logic [1:0] ioPulse;
  logic [1:0] calcStart;
  logic [1:0] calcStop;
  logic [1:0] missInc;
  logic [1:0] ovrInc;
  logic [1:0] shortInc;
  logic [1:0] cycRun;
  logic [1:0] cycDone;
  logic [1:0] calcDone;
  logic [31:0] cycLast [2];
  logic [31:0] calcLast [2];
  logic [31:0] shiftMax [2];
  logic [31:0] calcMax [2];
  logic [31:0] dlyMin [2];
  logic [31:0] dlyMax [2];
  logic [31:0] cycMax [2];
  logic [15:0] missCnt [2];
  logic [15:0] ovrCnt [2];
  logic [15:0] shortCnt [2];
  logic [7:0] irqSet;
  logic [31:0] rdWord;
  logic rdOk;

  // byte-lane merge of a write into an old word
  function automatic logic [31:0] laneMerge(input logic [31:0] old,
    input logic [31:0] data, input logic [3:0] strb);
    for (int i = 0; i < 4; i++)
      laneMerge[i*8 +: 8] = strb[i] ? data[i*8 +: 8] : old[i*8 +: 8];
  endfunction

  // ==========================================================
  // event routing
  // index 0 is the output group, index 1 the input group
  assign ioPulse = {inSampledPulse, outAppliedPulse};
  assign calcStart = {inSampledPulse, sync0Pulse};
  assign calcStop = {inAvailPulse, sync1Pulse};
  assign measureEn = (regs_q.cmd[0] == `STPO_CMD_START) ||
    (regs_q.cmd[1] == `STPO_CMD_START); // [RQ3]

  // ==========================================================
  // per-group meters and counters
  for (genvar g = 0; g < 2; g++)
  begin : grp
    // only the DC codes enable the DC-only checks
    assign dcMode[g] = (regs_q.mode[g] == STPO_DC_SYNC0) ||
      (regs_q.mode[g] == STPO_DC_SYNC1);
    // sync0 to apply or sample
    stpo_interval u_shift
    (
      .clk(clk),
      .rstn(rstn),
      .startPulse(sync0Pulse),
      .stopPulse(ioPulse[g]),
      .clearPulse(startMeas),
      .measureEn(measureEn),
      .running(),
      .donePulse(),
      .lastNs(),
      .minNs(),
      .maxNs(shiftMax[g]) // [RQ12]
    );
    // out: sync0 to sync1; in: sample to availability
    stpo_interval u_calc
    (
      .clk(clk),
      .rstn(rstn),
      .startPulse(calcStart[g]),
      .stopPulse(calcStop[g]),
      .clearPulse(startMeas),
      .measureEn(measureEn),
      .running(),
      .donePulse(calcDone[g]),
      .lastNs(calcLast[g]),
      .minNs(),
      .maxNs(calcMax[g]) // [RQ11] [RQ13]
    );
    // sync1 to apply or sample
    stpo_interval u_delay
    (
      .clk(clk),
      .rstn(rstn),
      .startPulse(sync1Pulse),
      .stopPulse(ioPulse[g]),
      .clearPulse(startMeas),
      .measureEn(measureEn),
      .running(),
      .donePulse(),
      .lastNs(),
      .minNs(dlyMin[g]), // [RQ11] [RQ14]
      .maxNs(dlyMax[g])
    );
    // local processing time of one cycle
    stpo_interval #(.MAX_INIT(`STPO_RST_MIN_CYCLE)) u_cycle // [RQ6]
    (
      .clk(clk),
      .rstn(rstn),
      .startPulse(procStartPulse[g]),
      .stopPulse(procDonePulse[g]),
      .clearPulse(startMeas),
      .measureEn(measureEn),
      .running(cycRun[g]),
      .donePulse(cycDone[g]),
      .lastNs(cycLast[g]),
      .minNs(),
      .maxNs(cycMax[g])
    );
    // missed sync-manager events count only in operational DC mode
    assign missInc[g] = smMissedPulse[g] && opState && dcMode[g]; // [RQ7]
    // a new start while busy, or a run longer than the cycle time
    assign ovrInc[g] = opState && ((procStartPulse[g] && cycRun[g]) ||
      (cycDone[g] && (cycLast[g] > regs_q.cycle[g]))); // [RQ8]
    // both groups judge the same sync0 to sync1 spacing
    assign shortInc[g] = dcMode[g] && calcDone[0] &&
      (calcLast[0] < `STPO_MIN_SHIFT_NS); // [RQ9]
    stpo_event_counter u_miss
    (
      .clk(clk),
      .rstn(rstn),
      .inc(missInc[g]),
      .count(missCnt[g])
    );
    stpo_event_counter u_ovr
    (
      .clk(clk),
      .rstn(rstn),
      .inc(ovrInc[g]),
      .count(ovrCnt[g])
    );
    stpo_event_counter u_short
    (
      .clk(clk),
      .rstn(rstn),
      .inc(shortInc[g]),
      .count(shortCnt[g])
    );
    // status bits: miss, overrun, short shift, sync error
    assign irqSet[g*4 +: 4] = {ioPulse[g] && dcMode[g] && lateApply[g],
      shortInc[g], ovrInc[g], missInc[g]};
  end

  // ==========================================================
  // read decode
  // one mux for both groups; unmapped words answer SLVERR
  always_comb
  begin
    logic g;
    g = s_axi_araddr[`STPO_GRP_BIT];
    rdWord = 32'h0000_0000;
    rdOk = 1'b1;
    if (s_axi_araddr[`STPO_IRQ_BIT])
    begin
      case (s_axi_araddr[5:2])
        `STPO_F_IRQ_STAT: rdWord = {24'h00_0000, regs_q.irqStat};
        `STPO_F_IRQ_MASK: rdWord = {24'h00_0000, regs_q.irqMask};
        default: rdOk = 1'b0;
      endcase
      if (g)
        rdOk = 1'b0;
    end
    else
    begin
      case (s_axi_araddr[5:2])
        `STPO_F_COUNT: rdWord = {24'h00_0000, `STPO_PARAM_COUNT};
        `STPO_F_MODE: rdWord = {16'h0000, regs_q.mode[g]};
        `STPO_F_CYCLE: rdWord = regs_q.cycle[g];
        `STPO_F_SHIFT: rdWord = shiftMax[g];
        `STPO_F_SUPP: rdWord = {16'h0000, `STPO_MODES_SUPP}; // [RQ2]
        `STPO_F_MINCYC: rdWord = cycMax[g];
        `STPO_F_CALC: rdWord = calcMax[g];
        `STPO_F_MINDLY: rdWord = dlyMin[g];
        `STPO_F_CMD: rdWord = {16'h0000, regs_q.cmd[g]};
        `STPO_F_MAXDLY: rdWord = dlyMax[g];
        `STPO_F_MISSED: rdWord = {16'h0000, missCnt[g]};
        `STPO_F_OVERRUN: rdWord = {16'h0000, ovrCnt[g]};
        `STPO_F_SHORT: rdWord = {16'h0000, shortCnt[g]};
        `STPO_F_SYNCERR: rdWord = {31'h0000_0000, regs_q.syncErr[g]}; // [RQ10]
        default: rdOk = 1'b0;
      endcase
    end
  end

  // ==========================================================
  // next state
  always_comb
  begin
    logic g;
    logic wrOk;
    logic [31:0] nv;
    logic [7:0] irqClr;
    g = regs_q.awAddr[`STPO_GRP_BIT];
    wrOk = 1'b1;
    nv = 32'h0000_0000;
    irqClr = 8'h00;
    startMeas = 1'b0;
    regs_d = regs_q;
    // write address and data are taken in either order
    if (s_axi_awvalid && s_axi_awready)
    begin
      regs_d.awAddr = s_axi_awaddr;
      regs_d.awHave = 1'b1;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      regs_d.wData = s_axi_wdata;
      regs_d.wStrb = s_axi_wstrb;
      regs_d.wHave = 1'b1;
    end
    if (regs_q.awHave && regs_q.wHave)
    begin
      if (regs_q.awAddr[`STPO_IRQ_BIT])
      begin
        case (regs_q.awAddr[5:2])
          `STPO_F_IRQ_STAT: irqClr = regs_q.wStrb[0] ? regs_q.wData[7:0] : 8'h00;
          `STPO_F_IRQ_MASK:
          begin
            nv = laneMerge({24'h00_0000, regs_q.irqMask}, regs_q.wData, regs_q.wStrb);
            regs_d.irqMask = nv[7:0];
          end
          default: wrOk = 1'b0;
        endcase
        if (g)
          wrOk = 1'b0;
      end
      else
      begin
        case (regs_q.awAddr[5:2])
          `STPO_F_MODE:
          begin
            nv = laneMerge({16'h0000, regs_q.mode[g]}, regs_q.wData, regs_q.wStrb);
            regs_d.mode[g] = nv[15:0]; // [RQ1] [RQ15]
          end
          `STPO_F_CYCLE:
            regs_d.cycle[g] = laneMerge(regs_q.cycle[g], regs_q.wData,
              regs_q.wStrb); // [RQ16]
          `STPO_F_CMD:
          begin
            nv = laneMerge({16'h0000, regs_q.cmd[g]}, regs_q.wData, regs_q.wStrb);
            regs_d.cmd[g] = nv[15:0]; // [RQ3]
            // every write of start begins a fresh run, even a repeated one
            startMeas = (nv[15:0] == `STPO_CMD_START); // [RQ5]
          end
          // read-only entries take the write silently
          `STPO_F_COUNT, `STPO_F_SHIFT, `STPO_F_SUPP, `STPO_F_MINCYC,
          `STPO_F_CALC, `STPO_F_MINDLY, `STPO_F_MAXDLY, `STPO_F_MISSED,
          `STPO_F_OVERRUN, `STPO_F_SHORT, `STPO_F_SYNCERR: wrOk = 1'b1;
          default: wrOk = 1'b0;
        endcase
      end
      regs_d.awHave = 1'b0;
      regs_d.wHave = 1'b0;
      regs_d.bValid = 1'b1;
      regs_d.bResp = wrOk ? `STPO_RESP_OKAY : `STPO_RESP_SLVERR;
    end
    if (regs_q.bValid && s_axi_bready)
      regs_d.bValid = 1'b0;
    // read answers one cycle after the address is taken
    if (s_axi_arvalid && s_axi_arready)
    begin
      regs_d.rValid = 1'b1;
      regs_d.rData = rdWord;
      regs_d.rResp = rdOk ? `STPO_RESP_OKAY : `STPO_RESP_SLVERR;
    end
    if (regs_q.rValid && s_axi_rready)
      regs_d.rValid = 1'b0;
    // sync error follows each apply or sample, only in DC mode
    for (int i = 0; i < 2; i++)
      if (ioPulse[i])
        regs_d.syncErr[i] = dcMode[i] && lateApply[i]; // [RQ10]
    // set beats a clear in the same cycle
    regs_d.irqStat = (regs_q.irqStat & ~irqClr) | irqSet;
  end

  // ==========================================================
  // registers
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      regs_q <= '0;
      regs_q.mode[0] <= `STPO_RST_OUT_MODE; // [RQ15]
      regs_q.mode[1] <= `STPO_RST_IN_MODE; // [RQ1]
      regs_q.cycle[0] <= `STPO_RST_CYCLE; // [RQ16]
      regs_q.cycle[1] <= `STPO_RST_CYCLE;
    end
    else
      regs_q <= regs_d;
  end

  // ==========================================================
  // outputs
  // ready is withheld while a response waits, so one write at a time
  assign s_axi_awready = !regs_q.awHave && !regs_q.bValid;
  assign s_axi_wready = !regs_q.wHave && !regs_q.bValid;
  assign s_axi_bvalid = regs_q.bValid;
  assign s_axi_bresp = regs_q.bResp;
  assign s_axi_arready = !regs_q.rValid;
  assign s_axi_rvalid = regs_q.rValid;
  assign s_axi_rdata = regs_q.rData;
  assign s_axi_rresp = regs_q.rResp;
  assign outSyncMode = regs_q.mode[0];
  assign inSyncMode = regs_q.mode[1];
  assign outCycleTime = regs_q.cycle[0];
  assign inCycleTime = regs_q.cycle[1];
  assign measuring = measureEn;
  // level interrupt from flops, no extra latency stage
  assign irq = |(regs_q.irqStat & regs_q.irqMask);
endmodule
`default_nettype wire

//--- tb/stpo_regs_assertions.sv
// stpo_regs_assertions.sv: bus and register checks on stpo_regs
// assumes it is bound to stpo_regs and sees only its ports
`default_nettype none
module stpo_regs_chk
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [15:0] outSyncMode,
  input wire logic [15:0] inSyncMode,
  input wire logic [31:0] outCycleTime,
  input wire logic measuring
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);
  // ==========================================
  // handshake steps
  sequence wrTaken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence rdTaken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  // a read is refused only while its answer waits
  chk_ar_refused: assert property (s_axi_arready == !s_axi_rvalid)
    else $error("arready is not the inverse of rvalid");
  chk_rd_answer: assert property (rdTaken |=> s_axi_rvalid)
    else $error("read answer late");
  chk_rd_release: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("rvalid kept after handshake");
  chk_wr_busy: assert property (wrTaken |=> !s_axi_awready && !s_axi_wready)
    else $error("write channels not closed");
  chk_wr_answer: assert property (wrTaken |-> ##2 s_axi_bvalid)
    else $error("write answer late");
  chk_b_release: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("bvalid kept after handshake");
  // ==========================================
  // register values at the ports
  chk_reset_modes: assert property ($rose(rstn) |->
    outSyncMode == 16'h0001 && inSyncMode == 16'h0022)
    else $error("sync mode reset value wrong");
  chk_reset_cycle: assert property ($rose(rstn) |-> outCycleTime == 32'h000F4240)
    else $error("cycle time reset value wrong");
  // settings move only with a completed write
  chk_in_mode_wr: assert property ($changed(inSyncMode) |-> $rose(s_axi_bvalid))
    else $error("input mode changed without write");
  chk_out_mode_wr: assert property ($changed(outSyncMode) |-> $rose(s_axi_bvalid))
    else $error("output mode changed without write");
  chk_measure_wr: assert property ($changed(measuring) |-> $rose(s_axi_bvalid))
    else $error("measuring changed without write");
endmodule
bind stpo_regs stpo_regs_chk chk (.clk, .rstn, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .outSyncMode, .inSyncMode,
  .outCycleTime, .measuring);
`default_nettype wire

//--- tb/stpo_sync_src.sv
// stpo_sync_src.sv: model of the distributed-clock event source
// assumes one clock; every event is a one-cycle pulse launched after an edge
`default_nettype none
module stpo_sync_src
(
  input wire logic clk,
  output logic sync0Pulse,
  output logic sync1Pulse,
  output logic outAppliedPulse,
  output logic inSampledPulse,
  output logic inAvailPulse
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================
  // event sequencer
  // lines rest low between frames
  initial
  begin
    sync0Pulse = 1'b0;
    sync1Pulse = 1'b0;
    outAppliedPulse = 1'b0;
    inSampledPulse = 1'b0;
    inAvailPulse = 1'b0;
  end
  // sync1 a cycles after sync0, apply/sample b later, data ready 3 after that
  task automatic frame(input int a, input int b);
    sync0Pulse <= 1'b1;
    @(posedge clk) sync0Pulse <= 1'b0;
    repeat (a - 1) @(posedge clk);
    sync1Pulse <= 1'b1;
    @(posedge clk) sync1Pulse <= 1'b0;
    repeat (b - 1) @(posedge clk);
    outAppliedPulse <= 1'b1;
    inSampledPulse <= 1'b1;
    @(posedge clk) outAppliedPulse <= 1'b0;
    inSampledPulse <= 1'b0;
    repeat (2) @(posedge clk);
    inAvailPulse <= 1'b1;
    @(posedge clk) inAvailPulse <= 1'b0;
    repeat (3) @(posedge clk);
  endtask
endmodule
`default_nettype wire

//--- tb/tb_top.sv
// tb_top.sv: self-checking bench for stpo_regs
// assumes stpo_regs and the event source model are compiled beforehand
`default_nettype none
`define CHK(g, e) begin numChecks++; if ((g) !== (e)) begin errorCnt++; \
  $display("wrong value at %0t: got %h expected %h", $time, g, e); end end
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, outCycleTime, inCycleTime;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, opState = 1'b1;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [1:0] procStartPulse = 2'h0, procDonePulse = 2'h0, smMissedPulse = 2'h0;
  logic [1:0] lateApply = 2'h0;
  logic sync0Pulse, sync1Pulse, outAppliedPulse, inSampledPulse, inAvailPulse;
  logic measuring, irq;
  logic [15:0] outSyncMode, inSyncMode;
  int errorCnt = 0, numChecks = 0, cycles = 0;
  stpo_regs uut (.clk, .rstn, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .sync0Pulse, .sync1Pulse, .opState, .outAppliedPulse,
    .inSampledPulse, .inAvailPulse, .procStartPulse, .procDonePulse, .smMissedPulse,
    .lateApply, .outSyncMode, .inSyncMode, .outCycleTime, .inCycleTime, .measuring, .irq);
  stpo_sync_src src (.clk, .sync0Pulse, .sync1Pulse, .outAppliedPulse,
    .inSampledPulse, .inAvailPulse);
  // ==========================================
  // clock, watchdog and verdict
  always #5 clk = ~clk;
  task automatic summarize;
    $display("checks %0d mismatches %0d", numChecks, errorCnt);
    if (errorCnt == 0 && numChecks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // a hang counts as a mismatch; the run needs well under 2000 cycles
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      errorCnt++;
      summarize();
    end
  end
  // ==========================================
  // bus tasks: address and data offered together, each dropped when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do
    begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end
    while (s_axi_awvalid || s_axi_wvalid);
    // raised only once both are taken, so a back-to-back call never writes bready twice
    s_axi_bready <= 1'b1;
    do @(posedge clk); while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    `CHK(s_axi_bresp, r)
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r = 2'h0);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge clk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    s_axi_rready <= 1'b1;
    do @(posedge clk); while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    `CHK(s_axi_rdata, e)
    `CHK(s_axi_rresp, r)
  endtask
  // one-cycle pulse on a chosen event vector, then room for the counters to settle
  task automatic pulse(input int k, input logic [1:0] v);
    case (k)
      0: smMissedPulse <= v;
      1: procStartPulse <= v;
      default: procDonePulse <= v;
    endcase
    @(posedge clk);
    smMissedPulse <= 2'h0;
    procStartPulse <= 2'h0;
    procDonePulse <= 2'h0;
    repeat (3) @(posedge clk);
  endtask
  // ==========================================
  // scenarios
  task automatic t_reset;
    rd(8'h00, 32'h20);
    rd(8'h04, 32'h1);
    rd(8'h08, 32'h000F4240);
    `CHK(inCycleTime, 32'h000F4240)
    rd(8'h10, 32'hC807);
    rd(8'h14, 32'h0000E6DC);
    rd(8'h20, 32'h0);
    rd(8'h2C, 32'h0);
    rd(8'h30, 32'h0);
    rd(8'h34, 32'h0);
    rd(8'h3C, 32'h0);
    rd(8'h44, 32'h22);
    rd(8'h50, 32'hC807);
    rd(8'h54, 32'h0000E6DC);
    $display("reset values done");
  endtask
  task automatic t_modes;
    logic [15:0] codes [5] = '{16'h0, 16'h1, 16'h2, 16'h3, 16'h22};
    foreach (codes[i])
    begin
      wr(8'h44, {16'h0, codes[i]}, 2'h0);
      rd(8'h44, {16'h0, codes[i]});
      `CHK(inSyncMode, codes[i])
      if (i < 4) wr(8'h04, {16'h0, codes[i]}, 2'h0);
      if (i < 4) `CHK(outSyncMode, codes[i])
    end
    wr(8'h08, 32'h00002710, 2'h0);
    `CHK(outCycleTime, 32'h00002710)
    wr(8'h10, 32'h0, 2'h0);
    rd(8'h10, 32'hC807);
    wr(8'h28, 32'h5, 2'h2);
    rd(8'h28, 32'h0, 2'h2);
    $display("modes and map done");
  endtask
  task automatic t_measure;
    wr(8'h04, 32'h2, 2'h0);
    wr(8'h44, 32'h2, 2'h0);
    wr(8'h20, 32'h1, 2'h0);
    `CHK(measuring, 1'b1)
    src.frame(5, 3);
    src.frame(7, 2);
    pulse(1, 2'b01);
    pulse(2, 2'b01);
    rd(8'h18, 32'd70);
    rd(8'h0C, 32'd90);
    rd(8'h1C, 32'd20);
    rd(8'h24, 32'd30);
    rd(8'h14, 32'd40);
    rd(8'h4C, 32'd90);
    rd(8'h58, 32'd30);
    rd(8'h5C, 32'd20);
    rd(8'h64, 32'd30);
    rd(8'h34, 32'h2);
    rd(8'h74, 32'h2);
    wr(8'h20, 32'h0, 2'h0);
    `CHK(measuring, 1'b0)
    lateApply <= 2'b11;
    src.frame(9, 9);
    lateApply <= 2'b00;
    rd(8'h18, 32'd70);
    rd(8'h3C, 32'h1);
    rd(8'h7C, 32'h1);
    src.frame(200, 1);
    rd(8'h3C, 32'h0);
    rd(8'h34, 32'h3);
    wr(8'h60, 32'h1, 2'h0);
    rd(8'h18, 32'h0);
    rd(8'h14, 32'h0);
    $display("measurement done");
  endtask
  task automatic t_events;
    wr(8'h84, 32'h1, 2'h0);
    `CHK(irq, 1'b0)
    pulse(0, 2'b01);
    `CHK(irq, 1'b1)
    rd(8'h2C, 32'h1);
    wr(8'h80, 32'h1, 2'h0);
    `CHK(irq, 1'b0)
    wr(8'h04, 32'h1, 2'h0);
    pulse(0, 2'b01);
    rd(8'h2C, 32'h1);
    pulse(1, 2'b10);
    pulse(1, 2'b10);
    rd(8'h70, 32'h1);
    // an early start outside operational state must not count
    opState <= 1'b0;
    pulse(1, 2'b10);
    opState <= 1'b1;
    rd(8'h70, 32'h1);
    $display("event counters done");
  endtask
  // ==========================================
  // main sequence
  initial
  begin
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    t_reset();
    t_modes();
    t_measure();
    t_events();
    summarize();
  end
endmodule
`default_nettype wire
